// ===== logic/ifmc_pkg.sv
`default_nettype none
package ifmc_pkg;
    localparam logic [15:0] ADDR_REQ_LOW = 16'hFFE0;
    localparam logic [15:0] ADDR_REQ_HIGH = 16'hFFE1;
    localparam logic [15:0] ADDR_MASK_LOW = 16'hFFE4;
    localparam logic [15:0] ADDR_MASK_HIGH = 16'hFFE5;
    localparam logic [15:0] ADDR_EDGE_SEL = 16'hFFEC;
    localparam logic [7:0] RST_REQ = 8'h00;
    localparam logic [7:0] RST_MASK = 8'hFF;
    localparam logic [7:0] RST_EDGE = 8'h00;
    localparam logic [7:0] RST_PSW = 8'h02;
    localparam logic [7:0] PSW_FIXED_ONE = 8'h02;
    localparam int PSW_IE_BIT = 7;
    localparam int NUM_SRC = 9;
    localparam int SRC_WDT = 0;
    localparam int SRC_EXT0 = 1;
    localparam int SRC_ADC = 8;
    localparam int EDGE_SEL_POS0 = 2;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [3:0] NMI_VECTOR_ID = 4'hF;
    localparam logic [3:0] NO_VECTOR_ID = 4'hE;
    typedef enum logic [1:0] {
        IFMC_WDT_INTERVAL = 2'h0,
        IFMC_WDT_MODE1 = 2'h1,
        IFMC_WDT_MODE2 = 2'h2
    } ifmc_wdt_mode_t;
    typedef enum logic [2:0] {
        IFMC_ST_IDLE = 3'h1,
        IFMC_ST_WAIT = 3'h2,
        IFMC_ST_SERVE = 3'h4
    } ifmc_cpu_state_t;
endpackage
`default_nettype wire

// ===== logic/ifmc_if.sv
`default_nettype none
interface ifmc_if;
    logic wr_en;
    logic rd_en;
    logic bit_wr;
    logic [2:0] bit_sel;
    logic [15:0] addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic ei_cmd;
    logic di_cmd;
    logic psw_wr;
    logic [7:0] psw_wr_data;
    logic [7:0] program_status_word;
    logic irq_pending;
    logic [3:0] irq_id;
    logic irq_ack;
    modport device (
        input wr_en, rd_en, bit_wr, bit_sel, addr, wr_data, ei_cmd, di_cmd, psw_wr, psw_wr_data, irq_ack,
        output rd_data, program_status_word, irq_pending, irq_id
    );
    modport core (
        output wr_en, rd_en, bit_wr, bit_sel, addr, wr_data, ei_cmd, di_cmd, psw_wr, psw_wr_data, irq_ack,
        input rd_data, program_status_word, irq_pending, irq_id
    );
endinterface
`default_nettype wire

// ===== logic/ifmc_device.sv
// Function
// - Flag set by source or software, cleared by ack
// - Low request register bit order fixed
// - Request registers reset zero; high only bit0
// - Mask order matches; high mask upper bits one
// - Mask zero enables; masks reset to FFH
// - Acknowledge clears the source flag
// - Watchdog flag writable only in interval mode
// - Watchdog mask reads undefined in watchdog modes
// - Port 2 output changes set external flags
// - Two-bit edge select per external pin
// - Edge select fields at bits 7:2
// - Edge register whole byte; flags allow bits
// - Software sequence for changing edge selection
// - Status bit7 enable, bit1 one, reset 02H
// - Ack saves status and clears enable
// - Enable/disable commands and status byte access
// - Grant needs flag, clear mask, enable set
// - Watchdog non-maskable request beats everything
// - Fixed priority, watchdog highest, adc lowest
`default_nettype none
module ifmc_device (
    input wire logic sys_clk,
    input wire logic rst_n,
    ifmc_if.device bus,
    input wire ifmc_pkg::ifmc_wdt_mode_t wdt_mode,
    input wire logic watchdog_irq,
    input wire logic [2:0] ext_pin,
    input wire logic serial_rx_done_irq,
    input wire logic three_wire_done_irq,
    input wire logic serial_tx_done_irq,
    input wire logic timer8_match_irq,
    input wire logic timer16_match_irq,
    input wire logic adc_done_irq,
    output logic nmi_pending,
    output logic [7:0] edge_sel_out
);
    // ----------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ----------------------------------------------------------------
    logic [2:0] pin_meta_reg, pin_meta_next;
    logic [2:0] pin_sync_reg, pin_sync_next;
    logic [2:0] pin_last_reg, pin_last_next;
    logic [2:0] ext_edge;
    logic [7:0] edge_sel_reg, edge_sel_next;

    always_comb begin
        pin_meta_next = ext_pin;
        pin_sync_next = pin_meta_reg;
        pin_last_next = pin_sync_reg;
    end

    // Pin 2 shares port 2, so driving it as output also lands here
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_edge
            logic [1:0] sel;
            logic rise, fall;
            assign sel = edge_sel_reg[ifmc_pkg::EDGE_SEL_POS0 + 2 * gi +: 2];
            assign rise = pin_sync_reg[gi] & ~pin_last_reg[gi];
            assign fall = ~pin_sync_reg[gi] & pin_last_reg[gi];
            // Prohibited code 10 detects nothing
            assign ext_edge[gi] = (sel == ifmc_pkg::EDGE_FALL) ? fall :
                                  (sel == ifmc_pkg::EDGE_RISE) ? rise :
                                  (sel == ifmc_pkg::EDGE_BOTH) ? (rise | fall) : 1'b0;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Flags, masks, status word
    // ----------------------------------------------------------------
    logic [8:0] req_reg, req_next;
    logic [8:0] mask_reg, mask_next;
    logic [7:0] psw_reg, psw_next;
    logic [8:0] src_evt;
    logic [8:0] eligible;
    logic [3:0] grant_id;
    logic grant_any;
    logic wdt_interval;
    logic [8:0] wr_low_val, wr_mask_low_val;

    assign wdt_interval = (wdt_mode == ifmc_pkg::IFMC_WDT_INTERVAL);
    // bit order: 0 wdt, 1..3 ext, 4 rx/3-wire, 5 tx, 6 t8, 7 t16, 8 adc
    assign src_evt = {adc_done_irq, timer16_match_irq, timer8_match_irq, serial_tx_done_irq,
                      serial_rx_done_irq | three_wire_done_irq, ext_edge,
                      watchdog_irq & wdt_interval};

    assign eligible = req_reg & ~mask_reg & {9{psw_reg[ifmc_pkg::PSW_IE_BIT]}};

    always_comb begin
        grant_id = ifmc_pkg::NO_VECTOR_ID;
        grant_any = 1'b0;
        for (int i = ifmc_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                grant_id = 4'(i);
                grant_any = 1'b1;
            end
        end
        if (nmi_pending) begin
            grant_id = ifmc_pkg::NMI_VECTOR_ID;
            grant_any = 1'b1;
        end
    end

    always_comb begin
        wr_low_val = {req_reg[8], bus.wr_data};
        wr_mask_low_val = {mask_reg[8], bus.wr_data};
        if (bus.bit_wr) begin
            wr_low_val = req_reg;
            wr_low_val[bus.bit_sel] = bus.wr_data[0];
            wr_mask_low_val = mask_reg;
            wr_mask_low_val[bus.bit_sel] = bus.wr_data[0];
        end
    end

    always_comb begin
        req_next = req_reg;
        mask_next = mask_reg;
        edge_sel_next = edge_sel_reg;
        psw_next = psw_reg;
        if (bus.wr_en) begin
            if (bus.addr == ifmc_pkg::ADDR_REQ_LOW) begin
                req_next[7:1] = wr_low_val[7:1];
                if (wdt_interval) begin
                    req_next[0] = wr_low_val[0];
                end
            end else if (bus.addr == ifmc_pkg::ADDR_REQ_HIGH) begin
                req_next[8] = bus.bit_wr ? ((bus.bit_sel == 3'h0) ? bus.wr_data[0] : req_reg[8])
                                         : bus.wr_data[0];
            end else if (bus.addr == ifmc_pkg::ADDR_MASK_LOW) begin
                mask_next[7:0] = wr_mask_low_val[7:0];
            end else if (bus.addr == ifmc_pkg::ADDR_MASK_HIGH) begin
                mask_next[8] = bus.bit_wr ? ((bus.bit_sel == 3'h0) ? bus.wr_data[0] : mask_reg[8])
                                          : bus.wr_data[0];
            end else if (bus.addr == ifmc_pkg::ADDR_EDGE_SEL && !bus.bit_wr) begin
                edge_sel_next = {bus.wr_data[7:2], 2'h0};
            end
        end
        // Ack clears before hardware sets, so a fresh event survives
        if (bus.irq_ack && grant_any && grant_id != ifmc_pkg::NMI_VECTOR_ID) begin
            req_next[grant_id] = 1'b0;
        end
        req_next = req_next | src_evt;
        if (bus.psw_wr) begin
            psw_next = bus.psw_wr_data | ifmc_pkg::PSW_FIXED_ONE;
        end
        if (bus.ei_cmd) begin
            psw_next[ifmc_pkg::PSW_IE_BIT] = 1'b1;
        end
        if (bus.di_cmd) begin
            psw_next[ifmc_pkg::PSW_IE_BIT] = 1'b0;
        end
        if (bus.irq_ack && grant_any) begin
            psw_next[ifmc_pkg::PSW_IE_BIT] = 1'b0;
        end
    end

    logic nmi_reg, nmi_next;
    always_comb begin
        nmi_next = nmi_reg;
        if (bus.irq_ack && nmi_reg) begin
            nmi_next = 1'b0;
        end
        if (watchdog_irq && !wdt_interval) begin
            nmi_next = 1'b1;
        end
    end
    assign nmi_pending = nmi_reg;

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [7:0] rd_reg, rd_next;
    always_comb begin
        rd_next = 8'h00;
        if (bus.addr == ifmc_pkg::ADDR_REQ_LOW) begin
            rd_next = req_reg[7:0];
        end else if (bus.addr == ifmc_pkg::ADDR_REQ_HIGH) begin
            rd_next = {7'h00, req_reg[8]};
        end else if (bus.addr == ifmc_pkg::ADDR_MASK_LOW) begin
            rd_next = mask_reg[7:0];
            // Undefined in watchdog modes; we return bit 0 as zero
            if (!wdt_interval) begin
                rd_next[0] = 1'b0;
            end
        end else if (bus.addr == ifmc_pkg::ADDR_MASK_HIGH) begin
            rd_next = {7'h7F, mask_reg[8]};
        end else if (bus.addr == ifmc_pkg::ADDR_EDGE_SEL) begin
            rd_next = edge_sel_reg;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
            pin_last_reg <= 3'h0;
            req_reg <= {1'b0, ifmc_pkg::RST_REQ};
            mask_reg <= {1'b1, ifmc_pkg::RST_MASK};
            edge_sel_reg <= ifmc_pkg::RST_EDGE;
            psw_reg <= ifmc_pkg::RST_PSW;
            nmi_reg <= 1'b0;
            rd_reg <= 8'h00;
        end else begin
            pin_meta_reg <= pin_meta_next;
            pin_sync_reg <= pin_sync_next;
            pin_last_reg <= pin_last_next;
            req_reg <= req_next;
            mask_reg <= mask_next;
            edge_sel_reg <= edge_sel_next;
            psw_reg <= psw_next;
            nmi_reg <= nmi_next;
            rd_reg <= rd_next;
        end
    end

    assign bus.rd_data = rd_reg;
    assign bus.program_status_word = psw_reg;
    assign bus.irq_pending = grant_any;
    assign bus.irq_id = grant_id;
    assign edge_sel_out = edge_sel_reg;
endmodule
`default_nettype wire

// ===== logic/ifmc_core.sv
`default_nettype none
// Core end: turns user requests into bus cycles and acknowledges.
module ifmc_core (
    input wire logic sys_clk,
    input wire logic rst_n,
    ifmc_if.core bus,
    input wire logic user_wr,
    input wire logic user_rd,
    input wire logic user_bit,
    input wire logic [2:0] user_bit_sel,
    input wire logic [15:0] user_addr,
    input wire logic [7:0] user_wdata,
    input wire logic user_ei,
    input wire logic user_di,
    input wire logic user_psw_wr,
    input wire logic [7:0] user_psw_wdata,
    input wire logic user_ack_enable,
    output logic [7:0] user_rdata,
    output logic [7:0] saved_psw,
    output logic [3:0] served_id,
    output logic served_valid
);
    ifmc_pkg::ifmc_cpu_state_t state_reg, state_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [7:0] saved_reg, saved_next;
    logic [3:0] id_reg, id_next;
    logic rd_dly_reg, rd_dly_next;
    logic ack;

    // Acknowledge holds off while any register write (user_wr) is on the bus
    assign ack = (state_reg == ifmc_pkg::IFMC_ST_IDLE) && bus.irq_pending && user_ack_enable && !user_wr;

    always_comb begin
        state_next = state_reg;
        saved_next = saved_reg;
        id_next = id_reg;
        rd_dly_next = user_rd;
        rdata_next = rd_dly_reg ? bus.rd_data : rdata_reg;
        case (state_reg)
            ifmc_pkg::IFMC_ST_IDLE: begin
                if (ack) begin
                    saved_next = bus.program_status_word;
                    id_next = bus.irq_id;
                    state_next = ifmc_pkg::IFMC_ST_SERVE;
                end
            end
            ifmc_pkg::IFMC_ST_SERVE: begin
                state_next = ifmc_pkg::IFMC_ST_IDLE;
            end
            default: begin
                state_next = ifmc_pkg::IFMC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= ifmc_pkg::IFMC_ST_IDLE;
            rdata_reg <= 8'h00;
            saved_reg <= 8'h00;
            id_reg <= ifmc_pkg::NO_VECTOR_ID;
            rd_dly_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rdata_reg <= rdata_next;
            saved_reg <= saved_next;
            id_reg <= id_next;
            rd_dly_reg <= rd_dly_next;
        end
    end

    assign bus.wr_en = user_wr;
    assign bus.rd_en = user_rd;
    assign bus.bit_wr = user_bit;
    assign bus.bit_sel = user_bit_sel;
    assign bus.addr = user_addr;
    assign bus.wr_data = user_wdata;
    assign bus.ei_cmd = user_ei;
    assign bus.di_cmd = user_di;
    assign bus.psw_wr = user_psw_wr;
    assign bus.psw_wr_data = user_psw_wdata;
    assign bus.irq_ack = ack;
    assign user_rdata = rdata_reg;
    assign saved_psw = saved_reg;
    assign served_id = id_reg;
    assign served_valid = (state_reg == ifmc_pkg::IFMC_ST_SERVE);
endmodule
`default_nettype wire

// ===== dv/ifmc_monitor.sv
`default_nettype none
module ifmc_monitor (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic bit_wr,
    input wire logic [15:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic ei_cmd,
    input wire logic di_cmd,
    input wire logic [7:0] program_status_word,
    input wire logic irq_pending,
    input wire logic [3:0] irq_id,
    input wire logic irq_ack
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------
    // Status word
    // ----------------------------
    a_psw_after_reset: assert property ($rose(rst_n) |-> program_status_word == ifmc_pkg::RST_PSW)
        else $error("status word not 02 after reset");
    a_psw_bit_one: assert property (program_status_word[1]) else $error("status word bit 1 low");
    a_ei_sets: assert property (ei_cmd && !di_cmd && !irq_ack |=> program_status_word[7]) else $error("enable not set");
    a_di_clears: assert property (di_cmd |=> !program_status_word[7]) else $error("enable not cleared");
    a_ack_clears_ie: assert property (irq_ack |=> !program_status_word[7]) else $error("enable kept over ack");
    // Only the watchdog request may bypass the global enable
    a_grant_needs_ie: assert property (irq_pending && irq_id != ifmc_pkg::NMI_VECTOR_ID |-> program_status_word[7])
        else $error("grant with enable off");
    // ----------------------------
    // Register read back
    // ----------------------------
    a_mask_read_back: assert property ((wr_en && !bit_wr && addr == ifmc_pkg::ADDR_MASK_LOW)
        ##1 (!wr_en && addr == ifmc_pkg::ADDR_MASK_LOW)
        |=> rd_data == $past(wr_data, 2)) else $error("mask read back differs");
    a_req_high_zero: assert property (addr == 16'hFFE1 |=> rd_data[7:1] == 7'h00) else $error("request high bits");
    a_mask_high_ones: assert property (addr == 16'hFFE5 |=> rd_data[7:1] == 7'h7F) else $error("mask high bits");
    a_edge_low_zero: assert property (addr == 16'hFFEC |=> rd_data[1:0] == 2'h0) else $error("edge low bits");
    c_nmi_ack: cover property (irq_ack && irq_id == 4'hF);
    c_adc_ack: cover property (irq_ack && irq_id == 4'h8);
    c_bit_write: cover property (wr_en && bit_wr);
endmodule
`default_nettype wire

// ===== dv/interrupt_flag_mask_control_test.sv
`default_nettype none
module interrupt_flag_mask_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk;
    logic rst_n;
    logic usr_wr, usr_rd, usr_bit, ei, di, psw_wr, ack_en;
    logic [2:0] bsel;
    logic [2:0] pin;
    logic [15:0] addr;
    logic [7:0] wdata, pwdata, spsw, esel;
    logic [7:0] urd;
    logic [6:0] src;
    logic [3:0] sid;
    logic sval, nmi;
    ifmc_pkg::ifmc_wdt_mode_t mode;
    int mismatches, num_checks;
    int cycles = 0;
    ifmc_if bus_if ();
    ifmc_device u_ifmc_device (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus_if.device), .wdt_mode(mode),
        .watchdog_irq(src[0]), .ext_pin(pin), .serial_rx_done_irq(src[1]), .three_wire_done_irq(src[2]),
        .serial_tx_done_irq(src[3]), .timer8_match_irq(src[4]), .timer16_match_irq(src[5]),
        .adc_done_irq(src[6]), .nmi_pending(nmi), .edge_sel_out(esel));
    ifmc_core u_ifmc_core (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus_if.core), .user_wr(usr_wr),
        .user_rd(usr_rd), .user_bit(usr_bit), .user_bit_sel(bsel), .user_addr(addr), .user_wdata(wdata),
        .user_ei(ei), .user_di(di), .user_psw_wr(psw_wr), .user_psw_wdata(pwdata), .user_ack_enable(ack_en),
        .user_rdata(urd), .saved_psw(spsw), .served_id(sid), .served_valid(sval));
    ifmc_monitor u_ifmc_monitor (.sys_clk(sys_clk), .rst_n(rst_n), .wr_en(bus_if.wr_en),
        .bit_wr(bus_if.bit_wr), .addr(bus_if.addr), .wr_data(bus_if.wr_data), .rd_data(bus_if.rd_data),
        .ei_cmd(bus_if.ei_cmd), .di_cmd(bus_if.di_cmd), .program_status_word(bus_if.program_status_word), .irq_pending(bus_if.irq_pending),
        .irq_id(bus_if.irq_id), .irq_ack(bus_if.irq_ack));
    // ----------------------------
    // Helpers
    // ----------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, s);
            mismatches++;
        end
    endtask
    // Drive just after the edge so no input races the sampling edge
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr8(input logic [15:0] a, input logic [7:0] d);
        addr = a; wdata = d; usr_wr = 1'b1; cyc(1); usr_wr = 1'b0;
        // Idle edge so a following write never re-raises the strobe at once
        cyc(1);
    endtask
    task automatic wrb(input logic [15:0] a, input logic [2:0] b, input logic v);
        addr = a; bsel = b; wdata = {7'h00, v}; usr_bit = 1'b1; usr_wr = 1'b1; cyc(1); usr_wr = 1'b0; usr_bit = 1'b0;
    endtask
    task automatic rchk(input string n, input logic [15:0] a, input logic [7:0] e);
        addr = a; usr_rd = 1'b1; cyc(1); usr_rd = 1'b0;
        chk(n, bus_if.rd_data, e);
        cyc(1);
        chk(n, urd, e);
    endtask
    task automatic pulse(input logic [6:0] s);
        src = s; cyc(1); src = 7'h00;
    endtask
    task automatic cmd_ei();
        ei = 1'b1; cyc(1); ei = 1'b0;
    endtask
    task automatic wait_srv(input logic [3:0] e);
        int k;
        k = 0;
        while (sval !== 1'b1 && k < 20) begin
            cyc(1);
            k++;
        end
        chk("served valid", {7'h00, sval}, 8'h01);
        chk("served id", {4'h0, sid}, {4'h0, e});
    endtask
    // ----------------------------
    // Scenarios
    // ----------------------------
    task automatic t_reset();
        logic [15:0] a[6] = '{16'hFFE0, 16'hFFE1, 16'hFFE4, 16'hFFE5, 16'hFFEC, 16'hFFE2};
        logic [7:0] e[6] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
        foreach (a[i]) rchk("reset value", a[i], e[i]);
        chk("status reset", bus_if.program_status_word, 8'h02);
    endtask
    task automatic t_sources();
        int p[7] = '{0, 4, 4, 5, 6, 7, 8};
        for (int i = 0; i < 7; i++) begin
            pulse(7'h01 << i);
            rchk("source flag", p[i] < 8 ? 16'hFFE0 : 16'hFFE1, 8'h01 << (p[i] % 8));
            wr8(16'hFFE0, 8'h00);
            wr8(16'hFFE1, 8'h00);
        end
    endtask
    task automatic t_edges();
        logic [1:0] m[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
        foreach (m[i]) begin
            wr8(16'hFFEC, {m[i], m[i], m[i], 2'h3});
            chk("edge select", esel, {m[i], m[i], m[i], 2'h0});
            wr8(16'hFFE0, 8'h00);
            pin = 3'h7;
            cyc(5);
            rchk("rise flags", 16'hFFE0, (m[i] == 2'h1 || m[i] == 2'h3) ? 8'h0E : 8'h00);
            wr8(16'hFFE0, 8'h00);
            cyc(3);
            rchk("single set", 16'hFFE0, 8'h00);
            pin = 3'h0;
            cyc(5);
            rchk("fall flags", 16'hFFE0, (m[i] == 2'h0 || m[i] == 2'h3) ? 8'h0E : 8'h00);
            wr8(16'hFFE0, 8'h00);
        end
        wrb(16'hFFEC, 3'h6, 1'b1);
        rchk("edge bit write", 16'hFFEC, 8'hA8);
    endtask
    task automatic t_ack();
        wr8(16'hFFE4, 8'h00);
        rchk("mask low", 16'hFFE4, 8'h00);
        wrb(16'hFFE5, 3'h0, 1'b0);
        rchk("mask high", 16'hFFE5, 8'hFE);
        wrb(16'hFFE4, 3'h7, 1'b1);
        pulse(7'h70);
        chk("pending with ie off", {7'h00, bus_if.irq_pending}, 8'h00);
        ack_en = 1'b1;
        cmd_ei();
        wait_srv(4'h6);
        chk("saved status", spsw, 8'h82);
        chk("ie after ack", bus_if.program_status_word, 8'h02);
        cmd_ei();
        wait_srv(4'h8);
        rchk("masked left", 16'hFFE0, 8'h80);
        rchk("adc cleared", 16'hFFE1, 8'h00);
        ack_en = 1'b0;
        pwdata = 8'h80; psw_wr = 1'b1; cyc(1); psw_wr = 1'b0;
        chk("status write", bus_if.program_status_word, 8'h82);
        di = 1'b1; cyc(1); di = 1'b0;
        chk("status di", bus_if.program_status_word, 8'h02);
        wr8(16'hFFE0, 8'h00);
        wr8(16'hFFE4, 8'hFF);
        wr8(16'hFFE5, 8'hFF);
    endtask
    task automatic t_wdt();
        mode = ifmc_pkg::IFMC_WDT_MODE1;
        cyc(1);
        wrb(16'hFFE0, 3'h0, 1'b1);
        rchk("wdt flag locked", 16'hFFE0, 8'h00);
        rchk("wdt mask read", 16'hFFE4, 8'hFE);
        pulse(7'h01);
        chk("nmi raised", {7'h00, nmi}, 8'h01);
        ack_en = 1'b1;
        wait_srv(4'hF);
        ack_en = 1'b0;
        chk("nmi cleared", {7'h00, nmi}, 8'h00);
        mode = ifmc_pkg::IFMC_WDT_MODE2;
        rchk("wdt mask mode two", 16'hFFE4, 8'hFE);
        mode = ifmc_pkg::IFMC_WDT_INTERVAL;
        wrb(16'hFFE0, 3'h0, 1'b1);
        rchk("wdt flag open", 16'hFFE0, 8'h01);
    endtask
    // ----------------------------
    // Clock, limit and sequence
    // ----------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        {usr_wr, usr_rd, usr_bit, ei, di, psw_wr, ack_en, rst_n} = 8'h00;
        {bsel, pin, addr, wdata, pwdata, src} = '0;
        mode = ifmc_pkg::IFMC_WDT_INTERVAL;
        mismatches = 0;
        num_checks = 0;
        cyc(6);
        rst_n = 1'b1;
        t_reset();
        t_sources();
        t_edges();
        t_ack();
        t_wdt();
        close_out();
    end
endmodule
`default_nettype wire
